/* bench/lsrc_ctrl_assertions.sv */
// Purpose: concurrent checks on the ports of the light sensor block
// Assumes: the 16-bit count comes from the shared parameter
// Notes: bus pins are raw, so design changes are tied to scl low
`timescale 1ns/10ps
`default_nettype none
module lsrc_ctrl_assertions #(
   parameter int unsigned INT_CYCLES_16B = 65536
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic clk_osc_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic int_n_o,
   input wire logic [1:0] full_scale_span_o,
   input wire logic fe_integrate_o,
   input wire logic fe_ir_sel_o
);
   localparam int unsigned MAXC =
      (INT_CYCLES_16B > 4096) ? INT_CYCLES_16B : 4096;
   logic [16:0] cnt_q, cnt_d;
   always_comb begin
      cnt_d = fe_integrate_o ? cnt_q + 17'h00001 : 17'h00000;
   end
   always_ff @(posedge clk_osc_i or negedge rst_n_i) begin
      if (!rst_n_i) cnt_q <= 17'h00000;
      else cnt_q <= cnt_d;
   end
   property p_len;
      @(posedge clk_osc_i) disable iff (!rst_n_i) $fell(fe_integrate_o)
         |-> cnt_q inside {INT_CYCLES_16B, 17'h01000, 17'h00100, 17'h00010};
   endproperty
   a_len: assert property (p_len)
      else $error("integration length is not a legal count");
   property p_cap;
      @(posedge clk_osc_i) disable iff (!rst_n_i)
         fe_integrate_o |-> cnt_q < MAXC;
   endproperty
   a_cap: assert property (p_cap)
      else $error("integration runs too long");
   property p_min;
      @(posedge clk_osc_i) disable iff (!rst_n_i)
         $rose(fe_integrate_o) |=> fe_integrate_o [*8];
   endproperty
   a_min: assert property (p_min)
      else $error("integration ended too early");
   property p_ir;
      @(posedge clk_osc_i) disable iff (!rst_n_i)
         fe_integrate_o && $past(fe_integrate_o) |-> $stable(fe_ir_sel_o);
   endproperty
   a_ir: assert property (p_ir)
      else $error("source select moved during integration");
   property p_span;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         $changed(full_scale_span_o) |-> !scl_i;
   endproperty
   a_span: assert property (p_span)
      else $error("range output moved outside a bus write");
   property p_int_clr;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         $rose(int_n_o) |-> !scl_i && !$past(scl_i, 1);
   endproperty
   a_int_clr: assert property (p_int_clr)
      else $error("interrupt released outside a read byte end");
   property p_sda_chg;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         $changed(sda_oe_o) |-> !scl_i;
   endproperty
   a_sda_chg: assert property (p_sda_chg)
      else $error("data line moved while scl high");
   property p_sda_val;
      @(posedge clk_sys_i) disable iff (!rst_n_i) sda_o == 1'b0;
   endproperty
   a_sda_val: assert property (p_sda_val)
      else $error("open drain data value not low");
endmodule // lsrc_ctrl_assertions
bind lsrc_ctrl lsrc_ctrl_assertions #(.INT_CYCLES_16B(INT_CYCLES_16B))
   lsrc_ctrl_assertions_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .clk_osc_i(clk_osc_i), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .int_n_o(int_n_o),
   .full_scale_span_o(full_scale_span_o),
   .fe_integrate_o(fe_integrate_o), .fe_ir_sel_o(fe_ir_sel_o));
`default_nettype wire

/* bench/lsrc_host.sv */
// Purpose: two-wire bus host model for register reads and writes
// Assumes: sda_i is the resolved wire, pulled up when nobody pulls low
// Notes: phases of 10 clk_i cycles, above the 4-cycle minimum
`timescale 1ns/10ps
`default_nettype none
module lsrc_host #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   input wire logic clk_i,
   input wire logic sda_i,
   output var logic scl_o,
   output var logic sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic hold();
      repeat (10) @(posedge clk_i);
   endtask
   // sda moves a cycle after scl falls so no false start or stop is seen
   task automatic bit_io(input logic b, output logic r);
      @(posedge clk_i);
      sda_low_o <= !b;
      hold();
      scl_o <= 1'b1;
      hold();
      r = sda_i;
      scl_o <= 1'b0;
   endtask
   task automatic edge_pair(input logic first, input logic second);
      @(posedge clk_i);
      sda_low_o <= first;
      hold();
      scl_o <= 1'b1;
      hold();
      sda_low_o <= second;
      hold();
   endtask
   // the ninth slot is always released: single bytes end with no ack
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
         output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic head(input logic [7:0] a, output logic ok);
      logic [7:0] x;
      logic k0, k1;
      edge_pair(1'b0, 1'b1);
      scl_o <= 1'b0;
      xfer({ADDR, 1'b0}, x, k0);
      xfer(a, x, k1);
      ok = k0 & k1;
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
         output logic ok);
      logic [7:0] x;
      logic k0, k1;
      head(a, k0);
      xfer(d, x, k1);
      edge_pair(1'b1, 1'b0);
      ok = k0 & k1;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] q,
         output logic ok);
      logic [7:0] x;
      logic k0, k1, k2;
      head(a, k0);
      edge_pair(1'b0, 1'b1);
      scl_o <= 1'b0;
      xfer({ADDR, 1'b1}, x, k1);
      xfer(8'hFF, q, k2);
      edge_pair(1'b1, 1'b0);
      ok = k0 & k1;
   endtask
endmodule // lsrc_host
`default_nettype wire

/* bench/tb_lsrc_ctrl.sv */
// Purpose: self-checking bench of the light sensor mode and result block
// Assumes: host model drives the bus, bench holds the front-end code
// Notes: the 16-bit count is cut to 64 cycles to keep the run short
`timescale 1ns/10ps
`default_nettype none
`include "lsrc_consts.svh"
module tb_lsrc_ctrl;
   typedef struct {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } lsrc_row_t;
   localparam int unsigned CYC16 = 64;
   logic clk, osc, rst_n, scl, host_low, sda_w, sda_v, sda_oe, int_n;
   logic fe_on, ir, ir_seen;
   logic [1:0] span;
   logic [15:0] fe, want;
   int bad_count = 0, n_tests = 0, cyc = 0, n_conv = 0, cnt = 0, len = 0;
   int k;
   int ncyc [4] = '{CYC16, 4096, 256, 16};
   lsrc_row_t rows [9] = '{
      '{8'h01, 8'hFE, 8'h0E}, '{8'h01, 8'h07, 8'h07},
      '{8'h04, 8'h5A, 8'h5A}, '{8'h05, 8'hA5, 8'hA5},
      '{8'h02, 8'h77, 8'h00}, '{8'h03, 8'h77, 8'h00},
      '{8'h08, 8'h55, 8'h00}, '{8'h09, 8'hFF, 8'h00},
      '{8'h00, 8'h1C, 8'h00}};
   assign sda_w = !(host_low || sda_oe);
   lsrc_ctrl #(.INT_CYCLES_16B(CYC16)) lsrc_ctrl_inst (
      .clk_sys_i(clk), .rst_n_i(rst_n), .clk_osc_i(osc), .scl_i(scl),
      .sda_i(sda_w), .fe_count_i(fe), .sda_o(sda_v), .sda_oe_o(sda_oe),
      .int_n_o(int_n), .full_scale_span_o(span),
      .fe_integrate_o(fe_on), .fe_ir_sel_o(ir));
   lsrc_host #(.ADDR(`LSRC_DEV_ADDR)) lsrc_host_inst (
      .clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));
   initial begin
      clk = 1'b0;
      forever #20 clk = !clk;
   end
   // unrelated phase and rate to the system clock
   initial begin
      osc = 1'b0;
      #3.7;
      forever #3 osc = !osc;
   end
   always @(posedge osc) begin
      if (fe_on === 1'b1) begin
         cnt = cnt + 1;
         ir_seen = ir;
      end else if (cnt != 0) begin
         len = cnt;
         n_conv = n_conv + 1;
         cnt = 0;
      end
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc > 90000) begin
         bad_count = bad_count + 1;
         complete_run();
      end
   end
   task automatic complete_run();
      if (bad_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] w,
         input logic [15:0] got);
      n_tests++;
      if (got !== w) begin
         $display("wrong value %s expected %h seen %h", what, w, got);
         bad_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      lsrc_host_inst.write_reg(a, d, ok);
      check("write ack", 16'h0001, {15'h0000, ok});
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      logic ok;
      lsrc_host_inst.read_reg(a, q, ok);
      check("read ack", 16'h0001, {15'h0000, ok});
      check("register", {8'h00, e}, {8'h00, q});
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // a conversion may finish inside the write, so k is taken before it
   task automatic wait_conv(input int k0);
      for (int t = 0; t < 20000 && n_conv == k0; t++) @(posedge clk);
      repeat (20) @(posedge clk);
   endtask
   initial begin
      rst_n = 1'b0;
      fe = 16'hABCD;
      do_reset();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
         if (rows[i].a == 8'h01)
            check("span", {14'h0000, rows[i].e[1:0]}, {14'h0000, span});
      end
      do_reset();
      check("int_n", 16'h0001, {15'h0000, int_n});
      check("span", 16'h0000, {14'h0000, span});
      for (int a = 0; a < 6; a++) rd(8'(a), 8'h00);
      for (int r = 0; r < 4; r++) begin
         wr(8'h01, {4'h0, 2'(r), 2'b00});
         k = n_conv;
         wr(8'h00, r[0] ? 8'h20 : 8'h40);
         wait_conv(k);
         want = 16'hABCD >> (4 * r);
         check("cycles", 16'(ncyc[r]), 16'(len));
         check("ir", {15'h0000, !r[0]}, {15'h0000, ir_seen});
         rd(8'h02, want[7:0]);
         rd(8'h03, want[15:8]);
         check("single", 16'(k + 1), 16'(n_conv));
      end
      k = n_conv;
      wr(8'h00, 8'hC0);
      wait_conv(k + 1);
      check("ir cont", 16'h0001, {15'h0000, ir_seen});
      wr(8'h00, 8'h00);
      wr(8'h01, 8'h04);
      wr(8'h04, 8'hBC);
      wr(8'h05, 8'h0A);
      k = n_conv;
      wr(8'h00, 8'hA1);
      for (int i = 0; i < 3; i++) wait_conv(k + i);
      check("int_n", 16'h0001, {15'h0000, int_n});
      wait_conv(k + 3);
      check("int_n", 16'h0000, {15'h0000, int_n});
      wait_conv(k + 4);
      check("int_n", 16'h0000, {15'h0000, int_n});
      wr(8'h00, 8'h01);
      repeat (700) @(posedge clk);
      rd(8'h00, 8'h05);
      check("int_n", 16'h0001, {15'h0000, int_n});
      rd(8'h00, 8'h01);
      wr(8'h04, 8'h00);
      wr(8'h07, 8'h0A);
      k = n_conv;
      wr(8'h00, 8'h20);
      wait_conv(k);
      check("int_n", 16'h0001, {15'h0000, int_n});
      wr(8'h06, 8'hBC);
      k = n_conv;
      wr(8'h00, 8'h20);
      wait_conv(k);
      check("int_n", 16'h0000, {15'h0000, int_n});
      complete_run();
   end
endmodule // tb_lsrc_ctrl
`default_nettype wire

/* core/lsrc_consts.svh */
// Purpose: offsets, field positions, reset values and counts of the
//          light sensor mode and result block
// Assumes: included by bare name from the package and the core
// Notes:   one definition per number
`ifndef LSRC_CONSTS_SVH
`define LSRC_CONSTS_SVH

`define LSRC_REG_CMD_ONE 8'h00
`define LSRC_REG_CMD_TWO 8'h01
`define LSRC_REG_RES_LO 8'h02
`define LSRC_REG_RES_HI 8'h03
`define LSRC_REG_LTHR_LO 8'h04
`define LSRC_REG_LTHR_HI 8'h05
`define LSRC_REG_HTHR_LO 8'h06
`define LSRC_REG_HTHR_HI 8'h07
`define LSRC_REG_TEST 8'h08

`define LSRC_MODE_MSB 7
`define LSRC_MODE_LSB 5
`define LSRC_FLAG_BIT 2
`define LSRC_PERSIST_MSB 1
`define LSRC_PERSIST_LSB 0
`define LSRC_RES_MSB 3
`define LSRC_RES_LSB 2
`define LSRC_SCALE_MSB 1
`define LSRC_SCALE_LSB 0

`define LSRC_RST_CMD 8'h00
`define LSRC_RST_RESULT 16'h0000
`define LSRC_RST_LTHR 16'h0000
`define LSRC_RST_HTHR 16'hFFFF

`define LSRC_MODE_OFF 3'h0
`define LSRC_MODE_ALS_ONCE 3'h1
`define LSRC_MODE_IR_ONCE 3'h2
`define LSRC_MODE_ALS_CONT 3'h5
`define LSRC_MODE_IR_CONT 3'h6

`define LSRC_PERSIST_N0 5'h01
`define LSRC_PERSIST_N1 5'h04
`define LSRC_PERSIST_N2 5'h08
`define LSRC_PERSIST_N3 5'h10

`define LSRC_CYC_16B 65536
`define LSRC_CYC_12B 4096
`define LSRC_CYC_8B 256
`define LSRC_CYC_4B 16

// arbitrary neutral bus address
`define LSRC_DEV_ADDR 7'h2A

`endif

/* core/lsrc_ctrl.sv */
// Purpose: mode, range, resolution, result and threshold logic of a
//          light converter, reached as a serial two-wire bus slave
// Assumes: clk_osc_i is the converter oscillator; fe_count_i is the
//          full-resolution front-end code, stable at integration end
// Notes:   bus pins are sampled on clk_sys_i; results cross by handshake
`timescale 1ns/10ps
`default_nettype none
`include "lsrc_consts.svh"

// Contract
// - mode comes from bits 7..5 of offset zero, power-down after reset
// - modes: off, visible once, infrared once, visible and infrared continuous
// - bits 1..0 of command two pick one of four full-scale ranges
// - bits 3..2 of command two pick 65536, 4096, 256 or 16 cycles
// - integration lasts the selected number of oscillator cycles
// - command two resets to zero, upper four bits read zero
// - result low byte at 0x02, high byte at 0x03, read only
// - result is right-justified to the selected resolution
// - result updates at each conversion end, zero until the first
// - lower threshold is sixteen bits at offsets 0x04 and 0x05
// - visible result at or below lower threshold raises pin and flag
// - lower threshold bytes reset to zero
// - visible result at or above upper threshold also raises them
// - interrupt only after 1, 4, 8 or 16 consecutive outside results
// - interrupt pin is active low and holds until cleared
// - finishing a serial read of offset zero clears flag and pin
module lsrc_ctrl
   import lsrc_pkg::*;
#(
   parameter int unsigned INT_CYCLES_16B = `LSRC_CYC_16B,
   parameter logic [6:0] DEV_ADDR = `LSRC_DEV_ADDR
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic clk_osc_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [15:0] fe_count_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic int_n_o,
   output logic [1:0] full_scale_span_o,
   output logic fe_integrate_o,
   output logic fe_ir_sel_o
);

   // system domain state
   logic [2:0] scl_s_q, sda_s_q, req_s_q;
   lsrc_i2c_st_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d, tx_q, tx_d;
   logic rw_q, rw_d, oe_q, oe_d, nack_q, nack_d;
   lsrc_cfg_t cfg_q, cfg_d;
   logic [15:0] lthr_q, lthr_d, hthr_q, hthr_d, result_q, result_d;
   logic flag_q, flag_d, int_n_q, single_q, single_d;
   logic [4:0] pcnt_q, pcnt_d;
   logic run_q, run_d, ir_q, ir_d, ack_q, ack_d, evt_q;
   logic scl_rise, scl_fall, start, stop, res_evt;
   logic flag_set, flag_clr, wr_en, outside;
   logic [4:0] persist_n;
   logic [7:0] rd_byte;

   // osc domain state
   logic [1:0] orst_q, run_o_q, ir_o_q, ack_o_q;
   logic [1:0] resolution_sel_lo_o_q, resolution_sel_hi_o_q;
   lsrc_osc_st_t ost_q, ost_d;
   logic [15:0] ocnt_q, ocnt_d;
   logic [1:0] ores_q, ores_d;
   logic oir_q, oir_d, req_q, req_d, integ_q, integ_d, ocfg_ok;
   lsrc_result_t hold_q, hold_d;
   logic [1:0] res_sync;
   logic [3:0] ocfg_q;

   assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
   assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
   assign start = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
   assign stop = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
   assign res_evt = req_s_q[1] ^ req_s_q[2];

   // read data mux; unmapped and test offsets read zero
   always_comb begin
      unique case (ptr_q)
         `LSRC_REG_CMD_ONE: rd_byte = {cfg_q.mode, 2'h0, flag_q,
                                       cfg_q.persist};
         `LSRC_REG_CMD_TWO: rd_byte = {4'h0, cfg_q.res, cfg_q.scale};
         `LSRC_REG_RES_LO: rd_byte = result_q[7:0];
         `LSRC_REG_RES_HI: rd_byte = result_q[15:8];
         `LSRC_REG_LTHR_LO: rd_byte = lthr_q[7:0];
         `LSRC_REG_LTHR_HI: rd_byte = lthr_q[15:8];
         `LSRC_REG_HTHR_LO: rd_byte = hthr_q[7:0];
         `LSRC_REG_HTHR_HI: rd_byte = hthr_q[15:8];
         default: rd_byte = 8'h00;
      endcase
   end

   always_comb begin
      unique case (cfg_q.persist)
         2'h0: persist_n = `LSRC_PERSIST_N0;
         2'h1: persist_n = `LSRC_PERSIST_N1;
         2'h2: persist_n = `LSRC_PERSIST_N2;
         2'h3: persist_n = `LSRC_PERSIST_N3;
      endcase
   end

   // visible-light window compare against both thresholds
   assign outside = (hold_q.data <= lthr_q)
                    | (hold_q.data >= hthr_q);

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      tx_d = tx_q;
      rw_d = rw_q;
      oe_d = oe_q;
      nack_d = nack_q;
      flag_clr = 1'b0;
      wr_en = 1'b0;
      if (start) begin
         st_d = LSRC_I_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b0;
      end else if (stop) begin
         st_d = LSRC_I_IDLE;
         oe_d = 1'b0;
      end else begin
         if (scl_rise) begin
            if (st_q inside {LSRC_I_ADDR, LSRC_I_REG, LSRC_I_WR}) begin
               sh_d = {sh_q[6:0], sda_s_q[1]};
               cnt_d = cnt_q + 4'h1;
            end
            if (st_q == LSRC_I_RD) begin
               cnt_d = cnt_q + 4'h1;
            end
            if (st_q == LSRC_I_RD_ACK) begin
               nack_d = sda_s_q[1];
            end
         end
         if (scl_fall) begin
            unique case (st_q)
               LSRC_I_IDLE: st_d = LSRC_I_IDLE;
               LSRC_I_ADDR: if (cnt_q == 4'h8) begin
                  if (sh_q[7:1] == DEV_ADDR) begin
                     st_d = LSRC_I_ACK_ADDR;
                     rw_d = sh_q[0];
                     oe_d = 1'b1;
                  end else begin
                     st_d = LSRC_I_IDLE;
                  end
               end
               LSRC_I_ACK_ADDR: begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     tx_d = rd_byte;
                     oe_d = ~rd_byte[7];
                     st_d = LSRC_I_RD;
                  end else begin
                     oe_d = 1'b0;
                     st_d = LSRC_I_REG;
                  end
               end
               LSRC_I_REG: if (cnt_q == 4'h8) begin
                  ptr_d = sh_q;
                  oe_d = 1'b1;
                  st_d = LSRC_I_ACK_REG;
               end
               LSRC_I_ACK_REG, LSRC_I_ACK_WR: begin
                  oe_d = 1'b0;
                  cnt_d = 4'h0;
                  st_d = LSRC_I_WR;
               end
               LSRC_I_WR: if (cnt_q == 4'h8) begin
                  wr_en = 1'b1;
                  ptr_d = ptr_q + 8'h01;
                  oe_d = 1'b1;
                  st_d = LSRC_I_ACK_WR;
               end
               LSRC_I_RD: if (cnt_q == 4'h8) begin
                  oe_d = 1'b0;
                  flag_clr = (ptr_q == `LSRC_REG_CMD_ONE);
                  ptr_d = ptr_q + 8'h01;
                  st_d = LSRC_I_RD_ACK;
               end else begin
                  oe_d = ~tx_q[3'(4'h7 - cnt_q)];
               end
               LSRC_I_RD_ACK: if (nack_q) begin
                  st_d = LSRC_I_IDLE;
               end else begin
                  tx_d = rd_byte;
                  oe_d = ~rd_byte[7];
                  cnt_d = 4'h0;
                  st_d = LSRC_I_RD;
               end
            endcase
         end
      end
   end

   always_comb begin
      cfg_d = cfg_q;
      lthr_d = lthr_q;
      hthr_d = hthr_q;
      result_d = result_q;
      pcnt_d = pcnt_q;
      single_d = single_q;
      flag_set = 1'b0;
      if (res_evt) begin
         result_d = hold_q.data;
         single_d = 1'b0;
         if (!hold_q.ir) begin
            if (outside) begin
               if (pcnt_q != 5'h1F) begin
                  pcnt_d = pcnt_q + 5'h01;
               end
               // compared against n minus one so a saturated count
               // cannot wrap to zero and lose the re-set
               flag_set = pcnt_q >= (persist_n - 5'h01);
            end else begin
               pcnt_d = 5'h00;
            end
         end
      end
      if (wr_en) begin
         unique case (ptr_q)
            `LSRC_REG_CMD_ONE: begin
               cfg_d.mode = sh_q[`LSRC_MODE_MSB:`LSRC_MODE_LSB];
               cfg_d.persist = sh_q[`LSRC_PERSIST_MSB:`LSRC_PERSIST_LSB];
               single_d = 1'b1;
            end
            `LSRC_REG_CMD_TWO: begin
               cfg_d.res = sh_q[`LSRC_RES_MSB:`LSRC_RES_LSB];
               cfg_d.scale = sh_q[`LSRC_SCALE_MSB:`LSRC_SCALE_LSB];
            end
            `LSRC_REG_LTHR_LO: lthr_d[7:0] = sh_q;
            `LSRC_REG_LTHR_HI: lthr_d[15:8] = sh_q;
            `LSRC_REG_HTHR_LO: hthr_d[7:0] = sh_q;
            `LSRC_REG_HTHR_HI: hthr_d[15:8] = sh_q;
            default: cfg_d = cfg_q;
         endcase
      end
      // a new hit in the clearing cycle keeps the flag set
      flag_d = (flag_q & ~flag_clr) | flag_set;
      // reserved codes are treated as power-down
      unique case (cfg_d.mode)
         `LSRC_MODE_ALS_ONCE, `LSRC_MODE_IR_ONCE: run_d = single_d;
         `LSRC_MODE_ALS_CONT, `LSRC_MODE_IR_CONT: run_d = 1'b1;
         default: run_d = 1'b0;
      endcase
      ir_d = cfg_d.mode[1] & ~cfg_d.mode[0];
      // ack one cycle after run drops so a single never runs twice
      ack_d = evt_q ? ~ack_q : ack_q;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         req_s_q <= 3'h0;
         st_q <= LSRC_I_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         oe_q <= 1'b0;
         nack_q <= 1'b1;
         cfg_q <= '0;
         lthr_q <= `LSRC_RST_LTHR;
         hthr_q <= `LSRC_RST_HTHR;
         result_q <= `LSRC_RST_RESULT;
         pcnt_q <= 5'h00;
         single_q <= 1'b0;
         flag_q <= 1'b0;
         int_n_q <= 1'b1;
         run_q <= 1'b0;
         ir_q <= 1'b0;
         ack_q <= 1'b0;
         evt_q <= 1'b0;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_i};
         sda_s_q <= {sda_s_q[1:0], sda_i};
         req_s_q <= {req_s_q[1:0], req_q};
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         tx_q <= tx_d;
         rw_q <= rw_d;
         oe_q <= oe_d;
         nack_q <= nack_d;
         cfg_q <= cfg_d;
         lthr_q <= lthr_d;
         hthr_q <= hthr_d;
         result_q <= result_d;
         pcnt_q <= pcnt_d;
         single_q <= single_d;
         flag_q <= flag_d;
         int_n_q <= ~flag_d;
         run_q <= run_d;
         ir_q <= ir_d;
         ack_q <= ack_d;
         evt_q <= res_evt;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = oe_q;
   assign int_n_o = int_n_q;
   assign full_scale_span_o = cfg_q.scale;

   // osc domain: reset released through two flops
   always_ff @(posedge clk_osc_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         orst_q <= 2'h0;
      end else begin
         orst_q <= {orst_q[0], 1'b1};
      end
   end

   // run, source and resolution are synced bit by bit and may land a
   // cycle apart, so a start waits until two samples in a row agree
   assign res_sync = {resolution_sel_hi_o_q[1], resolution_sel_lo_o_q[1]};
   assign ocfg_ok = ({run_o_q[1], ir_o_q[1], res_sync} == ocfg_q);

   always_comb begin
      ost_d = ost_q;
      ocnt_d = ocnt_q;
      ores_d = ores_q;
      oir_d = oir_q;
      req_d = req_q;
      hold_d = hold_q;
      unique case (ost_q)
         LSRC_O_IDLE: if (run_o_q[1] && ocfg_ok) begin
            ores_d = res_sync;
            oir_d = ir_o_q[1];
            unique case (res_sync)
               2'h0: ocnt_d = 16'(INT_CYCLES_16B - 1);
               2'h1: ocnt_d = 16'(`LSRC_CYC_12B - 1);
               2'h2: ocnt_d = 16'(`LSRC_CYC_8B - 1);
               2'h3: ocnt_d = 16'(`LSRC_CYC_4B - 1);
            endcase
            ost_d = LSRC_O_INT;
         end
         LSRC_O_INT: if (ocnt_q == 16'h0000) begin
            hold_d.data = fe_count_i >> {ores_q, 2'h0};
            hold_d.ir = oir_q;
            req_d = ~req_q;
            ost_d = LSRC_O_WAIT;
         end else begin
            ocnt_d = ocnt_q - 16'h0001;
         end
         LSRC_O_WAIT: if (ack_o_q[1] == req_q) begin
            ost_d = LSRC_O_IDLE;
         end
      endcase
      integ_d = (ost_d == LSRC_O_INT);
   end

   always_ff @(posedge clk_osc_i or negedge orst_q[1]) begin
      if (!orst_q[1]) begin
         run_o_q <= 2'h0;
         ir_o_q <= 2'h0;
         ack_o_q <= 2'h0;
         resolution_sel_lo_o_q <= 2'h0;
         resolution_sel_hi_o_q <= 2'h0;
         ost_q <= LSRC_O_IDLE;
         ocnt_q <= 16'h0000;
         ores_q <= 2'h0;
         oir_q <= 1'b0;
         req_q <= 1'b0;
         integ_q <= 1'b0;
         hold_q <= '0;
         ocfg_q <= 4'h0;
      end else begin
         run_o_q <= {run_o_q[0], run_q};
         ir_o_q <= {ir_o_q[0], ir_q};
         ack_o_q <= {ack_o_q[0], ack_q};
         resolution_sel_lo_o_q <= {resolution_sel_lo_o_q[0], cfg_q.res[0]};
         resolution_sel_hi_o_q <= {resolution_sel_hi_o_q[0], cfg_q.res[1]};
         ost_q <= ost_d;
         ocnt_q <= ocnt_d;
         ores_q <= ores_d;
         oir_q <= oir_d;
         req_q <= req_d;
         integ_q <= integ_d;
         hold_q <= hold_d;
         ocfg_q <= {run_o_q[1], ir_o_q[1], res_sync};
      end
   end

   assign fe_integrate_o = integ_q;
   assign fe_ir_sel_o = oir_q;

endmodule // lsrc_ctrl

`default_nettype wire

/* core/lsrc_pkg.sv */
// Purpose: types shared by the light sensor mode and result block
// Assumes: constants come from lsrc_consts.svh
// Notes:   none
`include "lsrc_consts.svh"
package lsrc_pkg;
   typedef struct packed {
      logic [2:0] mode;
      logic [1:0] persist;
      logic [1:0] res;
      logic [1:0] scale;
   } lsrc_cfg_t;

   typedef struct packed {
      logic [15:0] data;
      logic ir;
   } lsrc_result_t;

   typedef enum logic [3:0] {
      LSRC_I_IDLE, LSRC_I_ADDR, LSRC_I_ACK_ADDR, LSRC_I_REG, LSRC_I_ACK_REG,
      LSRC_I_WR, LSRC_I_ACK_WR, LSRC_I_RD, LSRC_I_RD_ACK
   } lsrc_i2c_st_t;

   typedef enum logic [1:0] {
      LSRC_O_IDLE, LSRC_O_INT, LSRC_O_WAIT
   } lsrc_osc_st_t;
endpackage
